// File: core/crsl_top.sv
/*
  Card command interpreter: decodes command headers written by firmware,
  tracks deferred response data and composes the two status bytes.
  Assumes an AXI4-Lite master on REF_CLK and firmware that posts each
  command's outcome before issuing the go write.
*/
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
module crsl_top (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic CMD_DONE
);
  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i]) res[i*8 +: 8] = new_v[i*8 +: 8];
    return res;
  endfunction

  // Firmware outcome to status word, byte one in the high half
  function automatic logic [15:0] outcome_sw(input crsl_pkg::crsl_outcome_t o);
    logic [15:0] sw;
    sw = {crsl_pkg::SW1_OK, crsl_pkg::ZERO_BYTE};
    case (o.code)
      crsl_pkg::OC_OK: if (o.pro) sw = {crsl_pkg::SW1_PROACT, o.pro_len};
      crsl_pkg::OC_RETRY: sw = {crsl_pkg::SW1_MEM, 4'h0, o.retry};
      crsl_pkg::OC_MEMFAIL: sw = {crsl_pkg::SW1_MEM, crsl_pkg::SW2_MEMFAIL};
      crsl_pkg::OC_NO_EF: sw = {crsl_pkg::SW1_REF, crsl_pkg::SW2_NO_EF};
      crsl_pkg::OC_RANGE: sw = {crsl_pkg::SW1_REF, crsl_pkg::SW2_RANGE};
      crsl_pkg::OC_NOT_FOUND: sw = {crsl_pkg::SW1_REF, crsl_pkg::SW2_NOT_FOUND};
      crsl_pkg::OC_INCONS: sw = {crsl_pkg::SW1_REF, crsl_pkg::SW2_INCONS};
      crsl_pkg::OC_NO_PIN: sw = {crsl_pkg::SW1_SEC, crsl_pkg::SW2_NO_PIN};
      crsl_pkg::OC_DENIED: sw = {crsl_pkg::SW1_SEC, crsl_pkg::SW2_DENIED};
      crsl_pkg::OC_PIN_CONF: sw = {crsl_pkg::SW1_SEC, crsl_pkg::SW2_PIN_CONF};
      crsl_pkg::OC_INV_CONF: sw = {crsl_pkg::SW1_SEC, crsl_pkg::SW2_INV_CONF};
      crsl_pkg::OC_BLOCKED: sw = {crsl_pkg::SW1_SEC, crsl_pkg::SW2_BLOCKED};
      crsl_pkg::OC_MAX_VAL: sw = {crsl_pkg::SW1_SEC, crsl_pkg::SW2_MAX_VAL};
      default: sw = {crsl_pkg::SW1_TECH, crsl_pkg::ZERO_BYTE};
    endcase
    return sw;
  endfunction

  // Access nibble to class; b4 of the nibble is its most significant bit
  function automatic logic [2:0] acc_class(input logic [3:0] nib);
    logic [2:0] c;
    c = crsl_pkg::ACC_ADMIN;
    case (nib)
      4'h0: c = crsl_pkg::ACC_ALWAYS;
      4'h1: c = crsl_pkg::ACC_PIN1;
      4'h2: c = crsl_pkg::ACC_PIN2;
      4'h3: c = crsl_pkg::ACC_RSVD;
      4'hF: c = crsl_pkg::ACC_NEVER;
      default: c = crsl_pkg::ACC_ADMIN;
    endcase
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  crsl_pkg::crsl_hdr_t hdr_r; // Command header under execution
  logic [7:0] len_r; // Length byte of the command
  crsl_pkg::crsl_outcome_t outc_r; // Firmware result for this command
  crsl_pkg::crsl_desc_t desc_r; // File descriptor being checked
  logic [15:0] sw_r; // Last status word
  logic pend_r; // Retrievable data held
  logic [7:0] plen_r; // Bytes held for retrieval
  crsl_pkg::crsl_state_t state_r; // Command sequencer
  logic done_r; // One-cycle completion pulse
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Both write channels are taken together so address and data pair up
  wire wr_take = S_AXI_AWVALID && S_AXI_WVALID && !awready_r && !bvalid_r;
  wire wr_fire = awready_r && wready_r;
  wire [7:0] wa = S_AXI_AWADDR;
  wire wa_hdr = (wa == crsl_pkg::OFS_CMD_HDR);
  wire wa_go = (wa == crsl_pkg::OFS_CMD_GO);
  wire wa_outc = (wa == crsl_pkg::OFS_OUTCOME);
  wire wa_desc = (wa == crsl_pkg::OFS_FILE_DESC);
  wire wa_ro = (wa == crsl_pkg::OFS_STATUS) || (wa == crsl_pkg::OFS_DESC_CHK);
  wire wa_ok = wa_hdr || wa_go || wa_outc || wa_desc || wa_ro;
  // A go write while a command runs is dropped; status stays coherent
  wire go_fire = wr_fire && wa_go && S_AXI_WSTRB[0] && (state_r == crsl_pkg::ST_IDLE);
  wire rd_take = S_AXI_ARVALID && !arready_r && !rvalid_r;

  // ----------------------------------------------------------------
  // Descriptor check and status view
  // ----------------------------------------------------------------
  wire fs_ok = (desc_r.fstruct == crsl_pkg::FS_TRANSP) ||
               (desc_r.fstruct == crsl_pkg::FS_LINEAR) ||
               (desc_r.fstruct == crsl_pkg::FS_CYCLIC);
  wire ft_ok = (desc_r.ftype == crsl_pkg::FT_ROOT) ||
               (desc_r.ftype == crsl_pkg::FT_DIR) ||
               (desc_r.ftype == crsl_pkg::FT_ELEM);
  // Two legality bits, four 3-bit access classes, spare bits zero
  wire [31:0] chk_word = {18'h00000, acc_class(desc_r[31:28]), acc_class(desc_r[27:24]),
                          acc_class(desc_r[23:20]), acc_class(desc_r[19:16]),
                          ft_ok, fs_ok};
  // Byte one of the status word sits in the low lane, spare bits zero
  wire crsl_pkg::crsl_status_t stat_view = {plen_r, 7'h00, pend_r,
                                            sw_r[7:0], sw_r[15:8]};

  // ----------------------------------------------------------------
  // Command evaluation
  // ----------------------------------------------------------------
  wire cla_ok = (hdr_r.cla == crsl_pkg::CLA_CARD);
  wire p12_zero = (hdr_r.p1 == crsl_pkg::ZERO_BYTE) && (hdr_r.p2 == crsl_pkg::ZERO_BYTE);
  wire is_seek2 = (hdr_r.ins == crsl_pkg::INS_SEEK) &&
                  (hdr_r.p2[7:4] == crsl_pkg::SEEK_TYPE2);
  wire is_elig = (hdr_r.ins == crsl_pkg::INS_AUTH) || is_seek2 ||
                 (hdr_r.ins == crsl_pkg::INS_SELECT) ||
                 (hdr_r.ins == crsl_pkg::INS_INCREASE);
  wire is_toolkit = (hdr_r.ins == crsl_pkg::INS_TERM_PROF) ||
                    (hdr_r.ins == crsl_pkg::INS_ENVELOPE) ||
                    (hdr_r.ins == crsl_pkg::INS_FETCH) ||
                    (hdr_r.ins == crsl_pkg::INS_TERM_RESP);
  wire is_known = is_elig || is_toolkit || (hdr_r.ins == crsl_pkg::INS_GET_RESP) ||
                  (hdr_r.ins == crsl_pkg::INS_SEEK) || (hdr_r.ins == 8'hF2) ||
                  (hdr_r.ins == 8'hB0) || (hdr_r.ins == 8'hD6) ||
                  (hdr_r.ins == 8'hB2) || (hdr_r.ins == 8'hDC) ||
                  (hdr_r.ins == 8'h20) || (hdr_r.ins == 8'h24) ||
                  (hdr_r.ins == 8'h26) || (hdr_r.ins == 8'h28) ||
                  (hdr_r.ins == 8'h2C) || (hdr_r.ins == 8'h04) ||
                  (hdr_r.ins == 8'h44) || (hdr_r.ins == 8'hFA);
  wire [15:0] base_sw = outcome_sw(outc_r);
  wire has_data = (outc_r.code == crsl_pkg::OC_OK) && (outc_r.resp_len != 8'h00);

  logic [15:0] sw_nxt;
  logic pend_nxt;
  logic [7:0] plen_nxt;
  always_comb
  begin
    // Any command drops held data unless it leaves fresh data or is a get response asking more than is held
    sw_nxt = base_sw;
    pend_nxt = 1'b0;
    plen_nxt = 8'h00;
    if (!cla_ok)
      sw_nxt = {crsl_pkg::SW1_BAD_CLA, crsl_pkg::ZERO_BYTE};
    else if (!is_known)
      sw_nxt = {crsl_pkg::SW1_BAD_INS, crsl_pkg::ZERO_BYTE};
    else if (hdr_r.ins == crsl_pkg::INS_GET_RESP)
    begin
      // Only valid after reset or straight after a command that left data
      if (!p12_zero)
        sw_nxt = {crsl_pkg::SW1_BAD_P12, crsl_pkg::ZERO_BYTE};
      else if (!pend_r)
        sw_nxt = {crsl_pkg::SW1_TECH, crsl_pkg::ZERO_BYTE};
      else if (len_r > plen_r)
      begin
        // Wrong length: tell the correct one, data stays retrievable
        sw_nxt = {crsl_pkg::SW1_BAD_P3, plen_r};
        pend_nxt = 1'b1;
        plen_nxt = plen_r;
      end
      else
      begin
        sw_nxt = outc_r.pro ? {crsl_pkg::SW1_PROACT, outc_r.pro_len} :
                              {crsl_pkg::SW1_OK, crsl_pkg::ZERO_BYTE};
      end
    end
    else if (is_toolkit)
    begin
      if (!p12_zero)
        sw_nxt = {crsl_pkg::SW1_BAD_P12, crsl_pkg::ZERO_BYTE};
      else if (outc_r.busy)
        sw_nxt = {crsl_pkg::SW1_BUSY, crsl_pkg::ZERO_BYTE};
      else if ((hdr_r.ins == crsl_pkg::INS_ENVELOPE) && has_data)
      begin
        // Acknowledgement above the limit is a firmware fault
        if (outc_r.resp_len > crsl_pkg::ENV_ACK_MAX)
          sw_nxt = {crsl_pkg::SW1_TECH, crsl_pkg::ZERO_BYTE};
        else
        begin
          sw_nxt = {crsl_pkg::SW1_RESP, outc_r.resp_len};
          pend_nxt = 1'b1;
          plen_nxt = outc_r.resp_len;
        end
      end
    end
    else if (is_elig && has_data)
    begin
      // Data waits for retrieval; length announced in byte two
      sw_nxt = {crsl_pkg::SW1_RESP, outc_r.resp_len};
      pend_nxt = 1'b1;
      plen_nxt = outc_r.resp_len;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and command state
  // ----------------------------------------------------------------
  // Evaluation takes one cycle after the go write
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_r <= crsl_pkg::ST_IDLE;
      done_r <= 1'b0;
      sw_r <= {crsl_pkg::SW1_OK, crsl_pkg::ZERO_BYTE};
      pend_r <= 1'b1;
      plen_r <= crsl_pkg::ROOT_RESP_LEN;
    end
    else if (CE)
    begin
      done_r <= 1'b0;
      case (state_r)
        crsl_pkg::ST_IDLE:
        begin
          if (go_fire) state_r <= crsl_pkg::ST_EXEC;
        end
        crsl_pkg::ST_EXEC:
        begin
          sw_r <= sw_nxt;
          pend_r <= pend_nxt;
          plen_r <= plen_nxt;
          done_r <= 1'b1;
          state_r <= crsl_pkg::ST_IDLE;
        end
        default: state_r <= crsl_pkg::ST_IDLE;
      endcase
    end
  end

  // Software-written registers
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      hdr_r <= '0;
      len_r <= 8'h00;
      outc_r <= '0;
      desc_r <= '0;
    end
    else if (CE && wr_fire)
    begin
      if (wa_hdr) hdr_r <= merge_strb(hdr_r, S_AXI_WDATA, S_AXI_WSTRB);
      if (go_fire) len_r <= S_AXI_WDATA[7:0];
      if (wa_outc)
      begin
        // Reserved field forced to zero so it reads back clean
        outc_r <= merge_strb(outc_r, S_AXI_WDATA, S_AXI_WSTRB) & 32'hFF03FFFF;
      end
      if (wa_desc) desc_r <= merge_strb(desc_r, S_AXI_WDATA, S_AXI_WSTRB);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= crsl_pkg::RESP_OKAY;
    end
    else if (CE)
    begin
      awready_r <= wr_take;
      wready_r <= wr_take;
      if (wr_fire)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= wa_ok ? crsl_pkg::RESP_OKAY : crsl_pkg::RESP_SLVERR;
      end
      else if (S_AXI_BREADY) bvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb
  begin
    rd_ok = 1'b1;
    case (S_AXI_ARADDR)
      crsl_pkg::OFS_CMD_HDR: rd_mux = hdr_r;
      crsl_pkg::OFS_CMD_GO: rd_mux = {24'h000000, len_r};
      crsl_pkg::OFS_OUTCOME: rd_mux = outc_r;
      crsl_pkg::OFS_STATUS: rd_mux = stat_view;
      crsl_pkg::OFS_FILE_DESC: rd_mux = desc_r;
      crsl_pkg::OFS_DESC_CHK: rd_mux = chk_word;
      default:
      begin
        rd_mux = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // Address taken one cycle after valid, data the cycle after that
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= crsl_pkg::RESP_OKAY;
    end
    else if (CE)
    begin
      arready_r <= rd_take;
      if (arready_r)
      begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= rd_ok ? crsl_pkg::RESP_OKAY : crsl_pkg::RESP_SLVERR;
      end
      else if (S_AXI_RREADY) rvalid_r <= 1'b0;
    end
  end

  assign S_AXI_AWREADY = awready_r;
  assign S_AXI_WREADY = wready_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = arready_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;
  assign CMD_DONE = done_r;
endmodule // crsl_top

// File: core/crsl_pkg.sv
/*
  Shared constants and carrier types for the card response and status
  logic: command codes, status words, register map and field layouts.
  Assumes the includer compiles this package before any module using it.
*/
package crsl_pkg;
  // ----------------------------------------------------------------
  // Command header codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CLA_CARD = 8'hA0;
  localparam logic [7:0] INS_GET_RESP = 8'hC0;
  localparam logic [7:0] INS_TERM_PROF = 8'h10;
  localparam logic [7:0] INS_ENVELOPE = 8'hC2;
  localparam logic [7:0] INS_FETCH = 8'h12;
  localparam logic [7:0] INS_TERM_RESP = 8'h14;
  localparam logic [7:0] INS_AUTH = 8'h88;
  localparam logic [7:0] INS_SEEK = 8'hA2;
  localparam logic [7:0] INS_SELECT = 8'hA4;
  localparam logic [7:0] INS_INCREASE = 8'h32;
  localparam logic [3:0] SEEK_TYPE2 = 4'h1;
  localparam logic [7:0] ENV_ACK_MAX = 8'h10;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // ----------------------------------------------------------------
  // Status word bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] SW1_OK = 8'h90;
  localparam logic [7:0] SW1_PROACT = 8'h91;
  localparam logic [7:0] SW1_MEM = 8'h92;
  localparam logic [7:0] SW1_BUSY = 8'h93;
  localparam logic [7:0] SW1_REF = 8'h94;
  localparam logic [7:0] SW1_SEC = 8'h98;
  localparam logic [7:0] SW1_RESP = 8'h9F;
  localparam logic [7:0] SW1_BAD_P3 = 8'h67;
  localparam logic [7:0] SW1_BAD_P12 = 8'h6B;
  localparam logic [7:0] SW1_BAD_INS = 8'h6D;
  localparam logic [7:0] SW1_BAD_CLA = 8'h6E;
  localparam logic [7:0] SW1_TECH = 8'h6F;
  localparam logic [7:0] SW2_MEMFAIL = 8'h40;
  localparam logic [7:0] SW2_NO_EF = 8'h00;
  localparam logic [7:0] SW2_RANGE = 8'h02;
  localparam logic [7:0] SW2_NOT_FOUND = 8'h04;
  localparam logic [7:0] SW2_INCONS = 8'h08;
  localparam logic [7:0] SW2_NO_PIN = 8'h02;
  localparam logic [7:0] SW2_DENIED = 8'h04;
  localparam logic [7:0] SW2_PIN_CONF = 8'h08;
  localparam logic [7:0] SW2_INV_CONF = 8'h10;
  localparam logic [7:0] SW2_BLOCKED = 8'h40;
  localparam logic [7:0] SW2_MAX_VAL = 8'h50;
  // ----------------------------------------------------------------
  // Outcome codes that firmware posts for the executed command
  // ----------------------------------------------------------------
  localparam logic [3:0] OC_OK = 4'h0;
  localparam logic [3:0] OC_RETRY = 4'h1;
  localparam logic [3:0] OC_MEMFAIL = 4'h2;
  localparam logic [3:0] OC_NO_EF = 4'h3;
  localparam logic [3:0] OC_RANGE = 4'h4;
  localparam logic [3:0] OC_NOT_FOUND = 4'h5;
  localparam logic [3:0] OC_INCONS = 4'h6;
  localparam logic [3:0] OC_NO_PIN = 4'h7;
  localparam logic [3:0] OC_DENIED = 4'h8;
  localparam logic [3:0] OC_PIN_CONF = 4'h9;
  localparam logic [3:0] OC_INV_CONF = 4'hA;
  localparam logic [3:0] OC_BLOCKED = 4'hB;
  localparam logic [3:0] OC_MAX_VAL = 4'hC;
  // ----------------------------------------------------------------
  // File descriptor codes and access classes
  // ----------------------------------------------------------------
  localparam logic [7:0] FS_TRANSP = 8'h00;
  localparam logic [7:0] FS_LINEAR = 8'h01;
  localparam logic [7:0] FS_CYCLIC = 8'h03;
  localparam logic [7:0] FT_ROOT = 8'h01;
  localparam logic [7:0] FT_DIR = 8'h02;
  localparam logic [7:0] FT_ELEM = 8'h04;
  localparam logic [2:0] ACC_ALWAYS = 3'h0;
  localparam logic [2:0] ACC_PIN1 = 3'h1;
  localparam logic [2:0] ACC_PIN2 = 3'h2;
  localparam logic [2:0] ACC_RSVD = 3'h3;
  localparam logic [2:0] ACC_ADMIN = 3'h4;
  localparam logic [2:0] ACC_NEVER = 3'h5;
  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CMD_HDR = 8'h00;
  localparam logic [7:0] OFS_CMD_GO = 8'h04;
  localparam logic [7:0] OFS_OUTCOME = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_FILE_DESC = 8'h10;
  localparam logic [7:0] OFS_DESC_CHK = 8'h14;
  localparam logic [7:0] ROOT_RESP_LEN = 8'h16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] p2;
    logic [7:0] p1;
    logic [7:0] ins;
    logic [7:0] cla;
  } crsl_hdr_t;
  typedef struct packed {
    logic [7:0] pro_len;
    logic [5:0] rsvd;
    logic busy;
    logic pro;
    logic [7:0] resp_len;
    logic [3:0] retry;
    logic [3:0] code;
  } crsl_outcome_t;
  typedef struct packed {
    logic [7:0] pend_len;
    logic [6:0] rsvd;
    logic pend;
    logic [7:0] sw2;
    logic [7:0] sw1;
  } crsl_status_t;
  typedef struct packed {
    logic [7:0] acc_hi;
    logic [7:0] acc_mid;
    logic [7:0] ftype;
    logic [7:0] fstruct;
  } crsl_desc_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } crsl_state_t;
endpackage

// File: dv/crsl_asserts.sv
/* Port checker for crsl_top, bound at the foot of this file.
   Assumes CE is held high and the bus is driven one request at a time. */
`timescale 1ns/10ps
module crsl_asserts (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic CMD_DONE
);
  logic [7:0] ra_r; // Address of the read in flight
  // Keep the read address, since the master releases it early
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST) ra_r <= 8'h00;
    else if (S_AXI_ARVALID && S_AXI_ARREADY) ra_r <= S_AXI_ARADDR;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  sequence s_go;
    S_AXI_AWREADY && S_AXI_AWADDR == crsl_pkg::OFS_CMD_GO;
  endsequence
  sequence s_done;
    ##2 CMD_DONE;
  endsequence
  a_wr_pair: assert property (S_AXI_AWREADY |-> S_AXI_WREADY && S_AXI_WVALID)
    else $error("Write channels taken apart");
  a_b_after: assert property (S_AXI_AWREADY |=> S_AXI_BVALID)
    else $error("Write response late");
  a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("Write response dropped");
  a_r_after: assert property (S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("Read data late");
  a_go_done: assert property (s_go |-> s_done)
    else $error("Command done pulse misplaced");
  a_stat_rsvd: assert property (S_AXI_RVALID && ra_r == 8'h0C |-> S_AXI_RDATA[23:17] == 7'h00)
    else $error("Status spare bits set");
  a_chk_rsvd: assert property (S_AXI_RVALID && ra_r == 8'h14 |-> S_AXI_RDATA[31:14] == 18'h0)
    else $error("Descriptor check spare bits set");
  a_unmapped: assert property (S_AXI_RVALID && ra_r > 8'h14 |-> S_AXI_RRESP == 2'h2)
    else $error("Unmapped read not refused");
endmodule // crsl_asserts
bind crsl_top crsl_asserts u_crsl_asserts (.REF_CLK(REF_CLK), .NRST(NRST),
  .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID), .CMD_DONE(CMD_DONE));

// File: dv/crsl_term_model.sv
/* Terminal side bus master: one write or read at a time.
   Assumes tasks are entered just after a rising clock edge. */
`timescale 1ns/10ps
module crsl_term_model (
  input wire logic clk,
  output logic [7:0] awaddr = 8'h00,
  output logic awvalid = 1'h0,
  output logic [31:0] wdata = 32'h0,
  output logic wvalid = 1'h0,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic [1:0] bresp,
  output logic bready = 1'h0,
  output logic [7:0] araddr = 8'h00,
  output logic arvalid = 1'h0,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  output logic rready = 1'h0
);
  // Write; each channel held until its own ready, response accepted
  // one cycle late so the slave must hold it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    fork
      begin
        do @(posedge clk); while (!awready);
        awvalid <= 1'h0;
        awaddr <= ~a; // Released lines must not keep the old value
      end
      begin
        do @(posedge clk); while (!wready);
        wvalid <= 1'h0;
        wdata <= ~d;
      end
    join
    @(posedge clk);
    bready <= 1'h1;
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'h0;
  endtask
  // Read; data accepted as soon as offered
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    araddr <= ~a;
    rready <= 1'h1;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    rready <= 1'h0;
  endtask
endmodule // crsl_term_model

// File: dv/test_crsl_top.sv
/* Self-checking bench for crsl_top driven through the terminal model.
   Assumes the package and design are compiled first. */
`timescale 1ns/10ps
module test_crsl_top;
  logic REF_CLK = 1'h0;
  logic NRST = 1'h0;
  wire logic [7:0] awaddr, araddr;
  wire logic [31:0] wdata, rdata;
  wire logic [1:0] bresp, rresp;
  wire logic awvalid, awready, wvalid, bvalid, bready, arvalid, arready, rvalid, rready;
  wire logic wready;
  int bad_count = 0;
  int n_tests = 0;
  logic [31:0] st;
  logic [1:0] rs;
  always #10 REF_CLK = ~REF_CLK;
  crsl_top u_crsl_top (.REF_CLK(REF_CLK), .NRST(NRST), .CE(1'h1), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CMD_DONE());
  crsl_term_model u_crsl_term_model (.clk(REF_CLK), .awaddr(awaddr), .awvalid(awvalid),
    .wdata(wdata), .wvalid(wvalid), .awready(awready), .wready(wready), .bvalid(bvalid),
    .bresp(bresp),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rdata(rdata), .rready(rready));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic results;
    if (bad_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One command, then compare SW1 SW2 of the status register
  task automatic cmd(input logic [7:0] ins, input logic [7:0] p2, input logic [31:0] oc,
    input logic [7:0] len, input logic [15:0] sw);
    u_crsl_term_model.wr(8'h00, {p2, 8'h00, ins, crsl_pkg::CLA_CARD}, rs);
    u_crsl_term_model.wr(8'h08, oc, rs);
    u_crsl_term_model.wr(8'h04, {24'h000000, len}, rs);
    u_crsl_term_model.rd(8'h0C, st);
    chk({16'h0000, st[7:0], st[15:8]}, {16'h0000, sw});
  endtask
  task automatic t_root;
    u_crsl_term_model.rd(8'h0C, st);
    chk(st, 32'h1601_0090);
    cmd(8'hC0, 8'h00, 32'h0, 8'h16, 16'h9000);
    cmd(8'hC0, 8'h00, 32'h0, 8'h16, 16'h6F00);
  endtask
  task automatic t_elig;
    logic [7:0] it [4] = '{8'h88, 8'hA2, 8'hA4, 8'h32};
    logic [7:0] pt [4] = '{8'h00, 8'h10, 8'h00, 8'h00};
    for (int i = 0; i < 4; i++)
    begin
      cmd(it[i], pt[i], 32'h0000_0C00, 8'h00, 16'h9F0C);
      cmd(8'hC0, 8'h00, 32'h0, 8'h0C, 16'h9000);
    end
    cmd(8'hA2, 8'h00, 32'h0000_0C00, 8'h00, 16'h9000);
    cmd(8'hA4, 8'h00, 32'h0000_0C00, 8'h00, 16'h9F0C);
    cmd(8'h12, 8'h00, 32'h0, 8'h00, 16'h9000);
    cmd(8'hC0, 8'h00, 32'h0, 8'h0C, 16'h6F00);
  endtask
  task automatic t_tool;
    cmd(8'h10, 8'h00, 32'h0, 8'h05, 16'h9000);
    cmd(8'hC2, 8'h00, 32'h0000_1000, 8'h08, 16'h9F10);
    cmd(8'hC2, 8'h00, 32'h0, 8'h08, 16'h9000);
    cmd(8'hC2, 8'h00, 32'h0000_1100, 8'h08, 16'h6F00);
    cmd(8'h12, 8'h00, 32'h2001_0000, 8'h20, 16'h9120);
    cmd(8'h14, 8'h00, 32'h0002_0000, 8'h03, 16'h9300);
    cmd(8'h14, 8'h00, 32'h0, 8'h03, 16'h9000);
  endtask
  task automatic t_codes;
    logic [15:0] ex [12] = '{16'h9203, 16'h9240, 16'h9400, 16'h9402, 16'h9404, 16'h9408,
      16'h9802, 16'h9804, 16'h9808, 16'h9810, 16'h9840, 16'h9850};
    for (int i = 0; i < 12; i++)
      cmd(8'hA4, 8'h00, {24'h000000, 4'h3, 4'(i + 1)}, 8'h00, ex[i]);
    // Holder pin check always carries eight digit bytes
    cmd(8'h20, 8'h01, 32'h0000_0008, 8'h08, 16'h9804);
  endtask
  task automatic t_desc;
    u_crsl_term_model.wr(8'h10, 32'hF410_0403, rs);
    u_crsl_term_model.rd(8'h14, st);
    chk(st, 32'h0000_2C23);
    u_crsl_term_model.wr(8'h10, 32'h0023_0002, rs);
    u_crsl_term_model.rd(8'h14, st);
    chk(st, 32'h0000_004C);
    u_crsl_term_model.rd(8'h18, st);
    chk(st, 32'h0000_0000);
    u_crsl_term_model.wr(8'h18, 32'h0, rs);
    chk({30'h0, rs}, {30'h0, crsl_pkg::RESP_SLVERR});
  endtask
  // Main sequence
  initial
  begin
    repeat (12) @(posedge REF_CLK);
    NRST <= 1'h1;
    @(posedge REF_CLK);
    t_root();
    t_elig();
    t_tool();
    t_codes();
    t_desc();
    results();
  end
  // Watchdog, far beyond the several hundred cycles the tests take
  initial
  begin
    #400000;
    bad_count++;
    results();
  end
endmodule // test_crsl_top
